// ===== logic/adc_channel_gpio_id_regs.sv
// Our own choice: strobed register access.
`timescale 1ns/10ps
// Register bank: pin control, identification, channel table, setups, sequencing.
module adc_channel_gpio_id_regs #(
    parameter int NUM_CH = 16,
    parameter logic [15:0] DEVICE_ID = 16'h5a50 // Arbitrary value.
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [adc_regs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [adc_regs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [adc_regs_pkg::DATA_W-1:0] reg_rdata,
    input wire logic pin_zero_in,
    input wire logic pin_one_in,
    output logic pin_zero_out,
    output logic pin_zero_oe_n,
    output logic pin_one_out,
    output logic pin_one_oe_n,
    input wire logic conv_done,
    output logic conv_busy,
    output logic [adc_regs_pkg::CH_IDX_W-1:0] active_channel,
    output logic [adc_regs_pkg::SETUP_SEL_W-1:0] active_setup_choice,
    output logic [adc_regs_pkg::AIN_W-1:0] active_positive_input,
    output logic [adc_regs_pkg::AIN_W-1:0] active_negative_input,
    output logic [adc_regs_pkg::DATA_W-1:0] active_setup_cfg,
    output logic [adc_regs_pkg::DATA_W-1:0] active_filter_cfg,
    output logic [adc_regs_pkg::DATA_W-1:0] active_offset,
    output logic [adc_regs_pkg::DATA_W-1:0] active_gain
);
    import adc_regs_pkg::*;

    if (NUM_CH < 2 || NUM_CH > CH_SLOTS) begin : g_bad_ch
        $error("NUM_CH must lie between 2 and 16");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and address decode.

    logic [PIN_CTRL_W-1:0] pin_ctrl_r;
    logic [CH_W-1:0] ch_r [NUM_CH];
    logic [DATA_W-1:0] setup_cfg_r [SETUP_COUNT];
    logic [DATA_W-1:0] filter_cfg_r [SETUP_COUNT];
    logic [DATA_W-1:0] offset_r [SETUP_COUNT];
    logic [DATA_W-1:0] gain_r [SETUP_COUNT];
    logic [DATA_W-1:0] rdata_nxt;
    logic [NUM_CH-1:0] ch_enable;
    logic [CH_IDX_W-1:0] seq_chan;
    logic seq_busy;
    logic [SETUP_SEL_W-1:0] cur_sel;
    logic pin_zero_readback;
    logic pin_one_readback;

    logic [CH_IDX_W-1:0] ch_idx;
    logic [SETUP_IDX_W-1:0] set_idx;
    logic hit_ch;
    logic hit_setup_cfg;
    logic hit_filter_cfg;
    logic hit_offset;
    logic hit_gain;

    assign ch_idx = reg_addr[CH_IDX_W-1:0];
    assign set_idx = reg_addr[SETUP_IDX_W-1:0];
    assign hit_ch = (reg_addr[ADDR_W-1:CH_IDX_W] == CH_BASE_ADDR[ADDR_W-1:CH_IDX_W])
        && (int'(ch_idx) < NUM_CH);
    assign hit_setup_cfg =
        reg_addr[ADDR_W-1:SETUP_IDX_W] == SETUP_CFG_BASE[ADDR_W-1:SETUP_IDX_W];
    assign hit_filter_cfg =
        reg_addr[ADDR_W-1:SETUP_IDX_W] == FILTER_CFG_BASE[ADDR_W-1:SETUP_IDX_W];
    assign hit_offset = reg_addr[ADDR_W-1:SETUP_IDX_W] == OFFSET_BASE[ADDR_W-1:SETUP_IDX_W];
    assign hit_gain = reg_addr[ADDR_W-1:SETUP_IDX_W] == GAIN_BASE[ADDR_W-1:SETUP_IDX_W];

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes. The identification register has no storage, so a write
    // to its address falls through every decode below and changes nothing.

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_ctrl_r <= '0;
        end else if (ce && reg_wr && reg_addr == PIN_CTRL_ADDR) begin
            pin_ctrl_r <= reg_wdata[PIN_CTRL_W-1:0];
        end
    end

    a_pin_ctrl_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && reg_addr == PIN_CTRL_ADDR
        |=> pin_ctrl_r == $past(reg_wdata[PIN_CTRL_W-1:0]))
        else $error("pin control write not stored");

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_r[i] <= (i == 0) ? CH0_RESET : CHN_RESET;
            end
        end else if (ce && reg_wr && hit_ch) begin
            // Reserved bits are forced low so a careless write cannot set them.
            ch_r[ch_idx] <= reg_wdata[CH_W-1:0] & CH_WRITE_MASK;
        end
    end

    // Writes to absent channel slots are dropped by the decode and not checked here.
    a_ch_field_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && hit_ch
        |=> ch_r[$past(ch_idx)] == ($past(reg_wdata[CH_W-1:0]) & CH_WRITE_MASK))
        else $error("channel fields not stored");
    a_ch_enable_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && hit_ch |=> ch_enable[$past(ch_idx)] == $past(reg_wdata[CH_EN_BIT]))
        else $error("channel enable not stored");

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < SETUP_COUNT; i++) begin
                setup_cfg_r[i] <= SETUP_RESET;
                filter_cfg_r[i] <= SETUP_RESET;
                offset_r[i] <= SETUP_RESET;
                gain_r[i] <= SETUP_RESET;
            end
        end else if (ce && reg_wr) begin
            if (hit_setup_cfg) begin
                setup_cfg_r[set_idx] <= reg_wdata;
            end
            if (hit_filter_cfg) begin
                filter_cfg_r[set_idx] <= reg_wdata;
            end
            if (hit_offset) begin
                offset_r[set_idx] <= reg_wdata;
            end
            if (hit_gain) begin
                gain_r[set_idx] <= reg_wdata;
            end
        end
    end

    a_setup_cfg_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && hit_setup_cfg |=> setup_cfg_r[$past(set_idx)] == $past(reg_wdata))
        else $error("setup word not stored");
    a_filter_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && hit_filter_cfg |=> filter_cfg_r[$past(set_idx)] == $past(reg_wdata))
        else $error("filter word not stored");
    a_offset_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && hit_offset |=> offset_r[$past(set_idx)] == $past(reg_wdata))
        else $error("offset word not stored");
    a_gain_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && hit_gain |=> gain_r[$past(set_idx)] == $past(reg_wdata))
        else $error("gain word not stored");

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads. Data stand for one cycle after the strobe, zero otherwise.

    always_comb begin
        rdata_nxt = '0;
        if (reg_addr == STATUS_ADDR) begin
            rdata_nxt[STATUS_BUSY_BIT] = seq_busy;
            rdata_nxt[STATUS_CHAN_LSB +: CH_IDX_W] = seq_chan;
        end else if (reg_addr == PIN_CTRL_ADDR) begin
            rdata_nxt[PIN_CTRL_W-1:0] = pin_ctrl_r;
            rdata_nxt[PIN_ZERO_LEVEL_BIT] = pin_zero_readback;
            rdata_nxt[PIN_ONE_LEVEL_BIT] = pin_one_readback;
        end else if (reg_addr == ID_ADDR) begin
            rdata_nxt[CH_W-1:0] = DEVICE_ID;
        end else if (hit_ch) begin
            rdata_nxt[CH_W-1:0] = ch_r[ch_idx] & CH_WRITE_MASK;
        end else if (hit_setup_cfg) begin
            rdata_nxt = setup_cfg_r[set_idx];
        end else if (hit_filter_cfg) begin
            rdata_nxt = filter_cfg_r[set_idx];
        end else if (hit_offset) begin
            rdata_nxt = offset_r[set_idx];
        end else if (hit_gain) begin
            rdata_nxt = gain_r[set_idx];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rdata_nxt : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // General-purpose pins.

    adc_pin_cell u_pin_zero (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .in_en(pin_ctrl_r[PIN_ZERO_IN_EN_BIT]),
        .out_en(pin_ctrl_r[PIN_ZERO_OUT_EN_BIT]),
        .level(pin_ctrl_r[PIN_ZERO_LEVEL_BIT]),
        .pin_in(pin_zero_in),
        .pin_out(pin_zero_out),
        .pin_oe_n(pin_zero_oe_n),
        .readback(pin_zero_readback)
    );

    adc_pin_cell u_pin_one (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .in_en(pin_ctrl_r[PIN_ONE_IN_EN_BIT]),
        .out_en(pin_ctrl_r[PIN_ONE_OUT_EN_BIT]),
        .level(pin_ctrl_r[PIN_ONE_LEVEL_BIT]),
        .pin_in(pin_one_in),
        .pin_out(pin_one_out),
        .pin_oe_n(pin_one_oe_n),
        .readback(pin_one_readback)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing and the values presented to the converter.

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            ch_enable[i] = ch_r[i][CH_EN_BIT];
        end
    end

    adc_channel_sequencer #(
        .NUM_CH(NUM_CH)
    ) u_seq (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .ch_enable(ch_enable),
        .conv_done(conv_done),
        .active_channel(seq_chan),
        .busy(seq_busy)
    );

    // Each channel indexes the shared setup table, so any mix of shared and
    // distinct setups works without extra logic.
    assign cur_sel = ch_r[seq_chan][SETUP_SEL_LSB +: SETUP_SEL_W];

    // Refreshed every enabled cycle, converting or idle, so setup edits apply at once.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            conv_busy <= 1'b0;
            active_channel <= '0;
            active_setup_choice <= '0;
            active_positive_input <= '0;
            active_negative_input <= '0;
            active_setup_cfg <= SETUP_RESET;
            active_filter_cfg <= SETUP_RESET;
            active_offset <= SETUP_RESET;
            active_gain <= SETUP_RESET;
        end else if (ce) begin
            conv_busy <= seq_busy;
            active_channel <= seq_chan;
            active_setup_choice <= cur_sel;
            active_positive_input <= ch_r[seq_chan][POS_LSB +: AIN_W];
            active_negative_input <= ch_r[seq_chan][NEG_LSB +: AIN_W];
            active_setup_cfg <= setup_cfg_r[cur_sel];
            active_filter_cfg <= filter_cfg_r[cur_sel];
            active_offset <= offset_r[cur_sel];
            active_gain <= gain_r[cur_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_id_read_value: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_rd && reg_addr == ID_ADDR
        |=> reg_rdata[CH_W-1:ID_DONT_CARE_W] == DEVICE_ID[CH_W-1:ID_DONT_CARE_W])
        else $error("identification read returned wrong code");
    a_id_write_ignored: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && reg_addr == ID_ADDR ##1 ce && reg_rd && reg_addr == ID_ADDR
        |=> reg_rdata[CH_W-1:0] == DEVICE_ID)
        else $error("identification changed after a write");
    a_rsvd_read_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_rd && hit_ch |=> reg_rdata[RSVD_LSB +: RSVD_W] == '0)
        else $error("reserved channel bits read nonzero");
    a_setup_field_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_wr && hit_ch && ch_idx == '0
        |=> ch_r[0][SETUP_SEL_LSB +: SETUP_SEL_W] == $past(reg_wdata[SETUP_SEL_LSB +: SETUP_SEL_W]))
        else $error("setup choice not stored");
    a_pin_input_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_rd && reg_addr == PIN_CTRL_ADDR && pin_ctrl_r[PIN_ZERO_IN_EN_BIT]
        |=> reg_rdata[PIN_ZERO_LEVEL_BIT] == $past(pin_zero_in))
        else $error("input pin level not read back");
    a_pin_idle_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_rd && reg_addr == PIN_CTRL_ADDR && !pin_ctrl_r[PIN_ONE_IN_EN_BIT]
        |=> reg_rdata[PIN_ONE_LEVEL_BIT] == $past(pin_ctrl_r[PIN_ONE_LEVEL_BIT]))
        else $error("written pin bit not read back");
    a_seq_starts_busy: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && arst_n && ch_enable != '0 ##1 ce |=> conv_busy)
        else $error("enabled channel did not start converting");
    a_setup_applied: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && seq_busy |=> active_gain == $past(gain_r[cur_sel])
            && active_offset == $past(offset_r[cur_sel]))
        else $error("selected setup values not applied");
    // Reset values, loaded while reset is low, are checked at the first edge after release.
    a_ch_reset_value: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(arst_n) |-> ch_r[0] == CH0_RESET && ch_enable[0])
        else $error("channel zero reset value wrong");
    a_pin_reset_state: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(arst_n) |-> pin_ctrl_r == '0 && pin_zero_oe_n && pin_one_oe_n)
        else $error("pin control not cleared by reset");
    a_ch_read_value: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_rd && hit_ch |=> reg_rdata == DATA_W'($past(ch_r[ch_idx])))
        else $error("channel read value wrong");
    a_pin_zero_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_rd && reg_addr == PIN_CTRL_ADDR && !pin_ctrl_r[PIN_ZERO_IN_EN_BIT]
        |=> reg_rdata[PIN_ZERO_LEVEL_BIT] == $past(pin_ctrl_r[PIN_ZERO_LEVEL_BIT]))
        else $error("written pin zero bit not read back");
    a_pin_one_input: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && reg_rd && reg_addr == PIN_CTRL_ADDR && pin_ctrl_r[PIN_ONE_IN_EN_BIT]
        |=> reg_rdata[PIN_ONE_LEVEL_BIT] == $past(pin_one_in))
        else $error("input pin one level not read back");
    a_active_follows: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce |=> active_channel == $past(seq_chan) && conv_busy == $past(seq_busy))
        else $error("active channel not presented");
    a_active_inputs: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce |=> active_positive_input == $past(ch_r[seq_chan][POS_LSB +: AIN_W])
            && active_negative_input == $past(ch_r[seq_chan][NEG_LSB +: AIN_W]))
        else $error("analog input codes not presented");
    a_setup_choice_out: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce |=> active_setup_choice == $past(cur_sel)
            && active_setup_cfg == $past(setup_cfg_r[cur_sel])
            && active_filter_cfg == $past(filter_cfg_r[cur_sel]))
        else $error("setup choice not presented");
endmodule

// ===== logic/adc_channel_sequencer.sv
`timescale 1ns/10ps
// Steps conversions through the enabled channels in ascending order.
module adc_channel_sequencer #(
    parameter int NUM_CH = 16
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [NUM_CH-1:0] ch_enable,
    input wire logic conv_done,
    output logic [adc_regs_pkg::CH_IDX_W-1:0] active_channel,
    output logic busy
);
    import adc_regs_pkg::*;

    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [CH_IDX_W-1:0] chan_r;
    logic [CH_IDX_W-1:0] chan_nxt;
    logic [CH_IDX_W-1:0] first_en;
    logic [CH_IDX_W-1:0] next_en;
    logic above_en;
    logic any_en;

    assign any_en = |ch_enable;

    // Descending scan so the last hit is the lowest qualifying channel.
    always_comb begin
        first_en = '0;
        next_en = '0;
        above_en = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (ch_enable[i]) begin
                first_en = CH_IDX_W'(i);
                if (CH_IDX_W'(i) > chan_r) begin
                    next_en = CH_IDX_W'(i);
                    above_en = 1'b1;
                end
            end
        end
        if (!above_en) begin
            next_en = first_en;
        end
    end

    always_comb begin
        state_nxt = state_r;
        chan_nxt = chan_r;
        unique case (state_r)
            SEQ_IDLE: begin
                if (any_en) begin
                    state_nxt = SEQ_CONVERT;
                    chan_nxt = first_en;
                end
            end
            SEQ_CONVERT: begin
                if (!any_en) begin
                    state_nxt = SEQ_IDLE;
                end else if (conv_done) begin
                    chan_nxt = next_en;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= SEQ_IDLE;
            chan_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            chan_r <= chan_nxt;
        end
    end

    assign active_channel = chan_r;
    assign busy = (state_r == SEQ_CONVERT);

    a_seq_step_up: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && busy && conv_done && above_en |=> chan_r > $past(chan_r))
        else $error("sequencer did not step to a higher channel");
    a_seq_wrap_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && busy && conv_done && any_en && !above_en |=> chan_r <= $past(chan_r))
        else $error("sequencer did not wrap to the lowest channel");
    a_seq_lands_enabled: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && busy && conv_done && any_en
        |=> |($past(ch_enable) & (NUM_CH'(1) << chan_r)))
        else $error("sequencer landed on a disabled channel");
endmodule

// ===== logic/adc_pin_cell.sv
`timescale 1ns/10ps
// One general-purpose pin: output drive, enable and readback selection.
module adc_pin_cell (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic in_en,
    input wire logic out_en,
    input wire logic level,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic readback
);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end else if (ce) begin
            pin_out <= level;
            pin_oe_n <= ~out_en;
        end
    end

    // A pin set up as input shows its level; otherwise the stored bit reads back.
    assign readback = in_en ? pin_in : level;

    a_pin_drive_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && out_en |=> !pin_oe_n && pin_out == $past(level))
        else $error("pin not driven with written level");
    a_pin_release_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && !out_en |=> pin_oe_n)
        else $error("pin still driven after output disable");
endmodule

// ===== logic/adc_regs_pkg.sv
// Shared constants and types for the converter register bank.
package adc_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam int CH_W = 16;
    localparam int CH_SLOTS = 16;
    localparam int CH_IDX_W = 4;
    localparam int SETUP_COUNT = 8;
    localparam int SETUP_SEL_W = 3;
    localparam int SETUP_IDX_W = 3;
    localparam int AIN_W = 5;
    localparam int PIN_CTRL_W = 6;
    localparam int ID_DONT_CARE_W = 4;

    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] PIN_CTRL_ADDR = 8'h06;
    localparam logic [ADDR_W-1:0] ID_ADDR = 8'h07;
    localparam logic [ADDR_W-1:0] CH_BASE_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] SETUP_CFG_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] FILTER_CFG_BASE = 8'h28;
    localparam logic [ADDR_W-1:0] OFFSET_BASE = 8'h30;
    localparam logic [ADDR_W-1:0] GAIN_BASE = 8'h38;

    localparam int PIN_ZERO_LEVEL_BIT = 0;
    localparam int PIN_ONE_LEVEL_BIT = 1;
    localparam int PIN_ZERO_OUT_EN_BIT = 2;
    localparam int PIN_ONE_OUT_EN_BIT = 3;
    localparam int PIN_ZERO_IN_EN_BIT = 4;
    localparam int PIN_ONE_IN_EN_BIT = 5;

    localparam int CH_EN_BIT = 15;
    localparam int SETUP_SEL_LSB = 12;
    localparam int RSVD_LSB = 10;
    localparam int RSVD_W = 2;
    localparam int POS_LSB = 5;
    localparam int NEG_LSB = 0;
    localparam logic [CH_W-1:0] CH_WRITE_MASK = 16'hf3ff;
    localparam logic [CH_W-1:0] CH0_RESET = 16'h8001;
    localparam logic [CH_W-1:0] CHN_RESET = 16'h0001;
    localparam logic [DATA_W-1:0] SETUP_RESET = 24'h000000;

    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_CHAN_LSB = 4;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_CONVERT = 1'b1
    } seq_state_t;
endpackage

// ===== verif/tb.sv
`timescale 1ns/10ps
// Self-checking testbench for the converter register bank.
module tb;
    import adc_regs_pkg::*;

    localparam logic [15:0] ID_VAL = 16'h5a50; // Arbitrary value.

    typedef struct packed {
        logic [7:0] a;
        logic [23:0] w;
        logic [23:0] m;
        logic [23:0] e;
    } row_t;

    logic clk_sys, arst_n, ce, reg_wr, reg_rd, conv_done, pin_zero_in, pin_one_in;
    logic [7:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata, d;
    logic pin_zero_out, pin_zero_oe_n, pin_one_out, pin_one_oe_n, conv_busy;
    logic [3:0] active_channel;
    logic [2:0] active_setup_choice;
    logic [4:0] active_positive_input, active_negative_input;
    logic [23:0] active_setup_cfg, active_filter_cfg, active_offset, active_gain;
    int n_errors = 0;
    int checks = 0;
    int sc[3] = '{0, 2, 3};
    logic [15:0] sv[3] = '{16'h9022, 16'ha043, 16'ha064};
    row_t rows[6] = '{
        '{ID_ADDR, 24'h00ffff, 24'hfffff0, {8'h00, ID_VAL[15:4], 4'h0}},
        '{CH_BASE_ADDR, 24'h000c23, 24'hffffff, 24'h000023},
        '{CH_BASE_ADDR, 24'h00ffff, 24'hffffff, 24'h00f3ff},
        '{CH_BASE_ADDR, 24'h005a5a, 24'hffffff, 24'h00525a},
        '{8'h08, 24'h123456, 24'hffffff, 24'h000000},
        '{CH_BASE_ADDR + 8'h01, 24'h00b3e1, 24'hffffff, 24'h00b3e1}
    };

    adc_channel_gpio_id_regs #(.NUM_CH(16), .DEVICE_ID(ID_VAL)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_zero_in(pin_zero_in), .pin_one_in(pin_one_in), .pin_zero_out(pin_zero_out),
        .pin_zero_oe_n(pin_zero_oe_n), .pin_one_out(pin_one_out),
        .pin_one_oe_n(pin_one_oe_n), .conv_done(conv_done), .conv_busy(conv_busy),
        .active_channel(active_channel), .active_setup_choice(active_setup_choice),
        .active_positive_input(active_positive_input),
        .active_negative_input(active_negative_input), .active_setup_cfg(active_setup_cfg),
        .active_filter_cfg(active_filter_cfg), .active_offset(active_offset),
        .active_gain(active_gain));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the taking edge, so sample just after it.
    task automatic rd(input logic [7:0] a, output logic [23:0] q);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
    endtask

    task automatic chk_active(input int i);
        logic [15:0] v;
        v = sv[i];
        chk("active channel", 24'(sc[i]), 24'(active_channel));
        chk("active setup", 24'(v[14:12]), 24'(active_setup_choice));
        chk("active positive", 24'(v[9:5]), 24'(active_positive_input));
        chk("active negative", 24'(v[4:0]), 24'(active_negative_input));
        chk("setup cfg", 24'h100000 | 24'(v[14:12]), active_setup_cfg);
        chk("filter cfg", 24'h200000 | 24'(v[14:12]), active_filter_cfg);
        chk("offset", 24'h300000 | 24'(v[14:12]), active_offset);
        chk("gain", 24'h400000 | 24'(v[14:12]), active_gain);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h000000;
        conv_done = 1'b0;
        pin_zero_in = 1'b0;
        pin_one_in = 1'b0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        chk("oe zero idle", 24'h1, 24'(pin_zero_oe_n));
        chk("oe one idle", 24'h1, 24'(pin_one_oe_n));
        rd(PIN_CTRL_ADDR, d);
        chk("pin control reset", 24'h000000, d);
        rd(CH_BASE_ADDR, d);
        chk("channel zero reset", 24'h008001, d);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            chk("register row", rows[i].e, d & rows[i].m);
        end
        for (int s = 0; s < 8; s++) begin
            wr(CH_BASE_ADDR + 8'h01, {9'h000, 3'(s), 12'h001});
            rd(CH_BASE_ADDR + 8'h01, d);
            chk("setup code", {9'h000, 3'(s), 12'h001}, d);
        end
        // Write and read strobes back to back, with no idle cycle between them.
        @(posedge clk_sys);
        reg_addr <= ID_ADDR;
        reg_wdata <= 24'h00ffff;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("id after write", {8'h00, ID_VAL[15:4], 4'h0}, reg_rdata & 24'hfffff0);
        $display("test register table done");
        wr(PIN_CTRL_ADDR, 24'h00000d);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("pin zero drive", 24'h1, {pin_zero_oe_n, pin_zero_out} == 2'b01 ? 24'h1 : 24'h0);
        chk("pin one drive", 24'h1, {pin_one_oe_n, pin_one_out} == 2'b00 ? 24'h1 : 24'h0);
        @(posedge clk_sys);
        pin_zero_in <= 1'b1;
        pin_one_in <= 1'b1;
        wr(PIN_CTRL_ADDR, 24'h000030);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("pin zero released", 24'h1, 24'(pin_zero_oe_n));
        rd(PIN_CTRL_ADDR, d);
        chk("pin input readback", 24'h000033, d);
        wr(PIN_CTRL_ADDR, 24'h000001);
        rd(PIN_CTRL_ADDR, d);
        chk("pin unconfigured readback", 24'h000001, d);
        $display("test pins done");
        do_reset();
        repeat (4) @(posedge clk_sys);
        #1;
        chk("busy after reset", 24'h1, 24'(conv_busy));
        for (int s = 0; s < 8; s++) begin
            wr(SETUP_CFG_BASE + 8'(s), 24'h100000 | 24'(s));
            wr(FILTER_CFG_BASE + 8'(s), 24'h200000 | 24'(s));
            wr(OFFSET_BASE + 8'(s), 24'h300000 | 24'(s));
            wr(GAIN_BASE + 8'(s), 24'h400000 | 24'(s));
        end
        for (int i = 0; i < 3; i++) begin
            wr(CH_BASE_ADDR + 8'(sc[i]), {8'h00, sv[i]});
        end
        repeat (3) @(posedge clk_sys);
        #1;
        chk_active(0);
        rd(STATUS_ADDR, d);
        chk("status busy", 24'h000001, d);
        for (int k = 1; k <= 6; k++) begin
            @(posedge clk_sys);
            conv_done <= 1'b1;
            @(posedge clk_sys);
            conv_done <= 1'b0;
            repeat (3) @(posedge clk_sys);
            #1;
            chk_active(k % 3);
        end
        for (int i = 0; i < 3; i++) begin
            wr(CH_BASE_ADDR + 8'(sc[i]), 24'h000000);
        end
        @(posedge clk_sys);
        conv_done <= 1'b1;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        chk("busy all disabled", 24'h0, 24'(conv_busy));
        $display("test sequencer done");
        give_verdict();
    end
endmodule
